/* File: src/xp_pkg.sv */
// Shared constants and state types for the crosspoint serial control block
package xp_pkg;

  // ****************************************
  // Array geometry and serial word layout
  // ****************************************
  localparam int NUM_OUT = 32;
  localparam int NUM_IN = 32;
  localparam int SRC_W = 5;
  localparam int FIELD_W = 6;
  localparam int WORD_BITS = 193;
  localparam int CLAMP_POS = 192;
  localparam int ON_POS = 5;
  localparam int SRC_POS = 0;
  localparam int SYNC_STAGES = 2;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] STATUS_OFF = 4'h0;
  localparam logic [3:0] ROUTE_SEL_OFF = 4'h4;
  localparam logic [3:0] ROUTE_DATA_OFF = 4'h8;
  localparam int STATUS_CLAMP_POS = 0;
  localparam int STATUS_SEL_POS = 1;
  localparam int STATUS_COUNT_POS = 8;
  localparam int ROUTE_STAGED_POS = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [4:0] ROUTE_SEL_RESET = 5'h00;

  // ****************************************
  // State types
  // ****************************************
  typedef struct packed {
    logic sclk1;
    logic sclk2;
    logic sclk3;
    logic sdi1;
    logic sdi2;
    logic csN1;
    logic csN2;
    logic updN1;
    logic updN2;
    logic [NUM_IN-1:0] main1;
    logic [NUM_IN-1:0] main2;
    logic [NUM_OUT-1:0] ovl1;
    logic [NUM_OUT-1:0] ovl2;
    logic [NUM_OUT-1:0] sel1;
    logic [NUM_OUT-1:0] sel2;
  } xp_front_t;

  typedef struct packed {
    logic [WORD_BITS-1:0] shiftReg;
    logic [WORD_BITS-1:0] active;
    logic [NUM_OUT-1:0] outData;
    logic [NUM_OUT-1:0] outEn;
    logic sdo;
    logic clampOn;
    logic [7:0] bitCount;
    logic [SRC_W-1:0] routeSel;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } xp_core_t;

endpackage

/* File: src/xp_pins_if.sv */
// Synchronised pin levels passed from the pin front end to the control core
`timescale 1ns/1ns
`default_nettype none
interface xp_pins_if;
  logic sclkRise;
  logic sdi;
  logic selN;
  logic applyN;
  logic [xp_pkg::NUM_IN-1:0] mainIn;
  logic [xp_pkg::NUM_OUT-1:0] ovlIn;
  logic [xp_pkg::NUM_OUT-1:0] ovlSel;

  modport front (
    output sclkRise, sdi, selN, applyN, mainIn, ovlIn, ovlSel
  );
  modport core (
    input sclkRise, sdi, selN, applyN, mainIn, ovlIn, ovlSel
  );
endinterface
`default_nettype wire

/* File: src/xp_pin_front.sv */
// Two-stage synchronisers for every pin and serial clock edge detection
`timescale 1ns/1ns
`default_nettype none
module xp_pin_front (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Raw pins
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic selectN,
  input wire logic applyN,
  input wire logic [xp_pkg::NUM_IN-1:0] mainInput,
  input wire logic [xp_pkg::NUM_OUT-1:0] overlayInput,
  input wire logic [xp_pkg::NUM_OUT-1:0] overlaySelect,
  // Synchronised side
  xp_pins_if.front pins
);
  xp_pkg::xp_front_t q;
  xp_pkg::xp_front_t d;

  always_comb begin
    d = q;
    d.sclk1 = serialClk;
    d.sclk2 = q.sclk1;
    d.sclk3 = q.sclk2;
    d.sdi1 = serialIn;
    d.sdi2 = q.sdi1;
    d.csN1 = selectN;
    d.csN2 = q.csN1;
    d.updN1 = applyN;
    d.updN2 = q.updN1;
    d.main1 = mainInput;
    d.main2 = q.main1;
    d.ovl1 = overlayInput;
    d.ovl2 = q.ovl1;
    d.sel1 = overlaySelect;
    d.sel2 = q.sel1;
  end

  // Deselect and no-apply are the safe levels held during reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.csN1 <= 1'b1;
      q.csN2 <= 1'b1;
      q.updN1 <= 1'b1;
      q.updN2 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Data is taken at the same stage as the edge so the two stay aligned
  assign pins.sclkRise = q.sclk2 & ~q.sclk3;
  assign pins.sdi = q.sdi2;
  assign pins.selN = q.csN2;
  assign pins.applyN = q.updN2;
  assign pins.mainIn = q.main2;
  assign pins.ovlIn = q.ovl2;
  assign pins.ovlSel = q.sel2;
endmodule
`default_nettype wire

/* File: src/xp_crosspoint_ctrl.sv */
// Crosspoint serial control core: two-rank routing latches, overlay muxes and AXI4-Lite view
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module xp_crosspoint_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Serial programming pins
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic selectN,
  input wire logic applyN,
  output logic serialOut,
  // Signal path
  input wire logic [xp_pkg::NUM_IN-1:0] mainInput,
  input wire logic [xp_pkg::NUM_OUT-1:0] overlayInput,
  input wire logic [xp_pkg::NUM_OUT-1:0] overlaySelect,
  output logic [xp_pkg::NUM_OUT-1:0] outData,
  output logic [xp_pkg::NUM_OUT-1:0] outEn,
  output logic clampOn,
  // AXI4-Lite write address and data
  input wire logic [xp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [xp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ****************************************
  // Pin front end
  // ****************************************
  // Every pin crosses two flops; pin-to-output latency is about three clocks
  xp_pins_if pins ();

  xp_pin_front u_front (
    .clk(clk),
    .resetn(resetn),
    .serialClk(serialClk),
    .serialIn(serialIn),
    .selectN(selectN),
    .applyN(applyN),
    .mainInput(mainInput),
    .overlayInput(overlayInput),
    .overlaySelect(overlaySelect),
    .pins(pins)
  );

  xp_pkg::xp_core_t q;
  xp_pkg::xp_core_t d;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    int base;
    logic [xp_pkg::SRC_W-1:0] src;
    logic routed;
    base = 0;
    src = '0;
    routed = 1'b0;
    d = q;

    // ****************************************
    // Staging rank
    // ****************************************
    // Shift only while selected, on a serial clock rise
    if (!pins.selN && pins.sclkRise) begin
      d.shiftReg = {q.shiftReg[xp_pkg::WORD_BITS-2:0], pins.sdi};
      if (q.bitCount != xp_pkg::COUNT_MAX) begin
        d.bitCount = q.bitCount + 8'h01;
      end
    end
    if (pins.selN) begin
      d.bitCount = '0;
    end
    d.sdo = d.shiftReg[xp_pkg::WORD_BITS-1];

    // ****************************************
    // Active rank
    // ****************************************
    // Transparent while apply and select are both low, so a low apply during
    // shifting drags the routing through every partial word
    if (!pins.selN && !pins.applyN) begin
      d.active = d.shiftReg;
    end // otherwise held

    d.clampOn = d.active[xp_pkg::CLAMP_POS];

    // ****************************************
    // Output decode and overlay mux
    // ****************************************
    // A disabled output still carries the mux value; only its enable matters
    for (int k = 0; k < xp_pkg::NUM_OUT; k++) begin
      base = k * xp_pkg::FIELD_W;
      src = d.active[base + xp_pkg::SRC_POS +: xp_pkg::SRC_W];
      routed = pins.mainIn[src];
      d.outData[k] = pins.ovlSel[k] ? pins.ovlIn[k] : routed;
      d.outEn[k] = d.active[base + xp_pkg::ON_POS];
    end

    // ****************************************
    // AXI4-Lite write
    // ****************************************
    // Address and data are taken together; a pending response blocks the next write
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.awready) begin
      d.awready = 1'b0;
      d.wready = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = xp_pkg::RESP_OKAY;
      unique case (s_axi_awaddr)
        xp_pkg::ROUTE_SEL_OFF: begin
          if (s_axi_wstrb[0]) begin
            d.routeSel = s_axi_wdata[xp_pkg::SRC_W-1:0];
          end
        end
        xp_pkg::STATUS_OFF, xp_pkg::ROUTE_DATA_OFF: begin
          d.bresp = xp_pkg::RESP_OKAY;
        end
        default: begin
          d.bresp = xp_pkg::RESP_SLVERR;
        end
      endcase
    end else if (!q.bvalid && s_axi_awvalid && s_axi_wvalid) begin
      d.awready = 1'b1;
      d.wready = 1'b1;
    end

    // ****************************************
    // AXI4-Lite read
    // ****************************************
    // Unmapped reads return zero data with an error response
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (q.arready) begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rdata = '0;
      d.rresp = xp_pkg::RESP_OKAY;
      base = int'(q.routeSel) * xp_pkg::FIELD_W;
      unique case (s_axi_araddr)
        xp_pkg::STATUS_OFF: begin
          d.rdata[xp_pkg::STATUS_CLAMP_POS] = q.clampOn;
          d.rdata[xp_pkg::STATUS_SEL_POS] = ~pins.selN;
          d.rdata[xp_pkg::STATUS_COUNT_POS +: 8] = q.bitCount;
        end
        xp_pkg::ROUTE_SEL_OFF: begin
          d.rdata[xp_pkg::SRC_W-1:0] = q.routeSel;
        end
        xp_pkg::ROUTE_DATA_OFF: begin
          d.rdata[xp_pkg::FIELD_W-1:0] = q.active[base +: xp_pkg::FIELD_W];
          d.rdata[xp_pkg::ROUTE_STAGED_POS +: xp_pkg::FIELD_W] =
            q.shiftReg[base +: xp_pkg::FIELD_W];
        end
        default: begin
          d.rresp = xp_pkg::RESP_SLVERR;
        end
      endcase
    end else if (!q.rvalid && s_axi_arvalid) begin
      d.arready = 1'b1;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // Reset clears both ranks, so every output comes up released
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.routeSel <= xp_pkg::ROUTE_SEL_RESET;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign serialOut = q.sdo;
  assign outData = q.outData;
  assign outEn = q.outEn;
  assign clampOn = q.clampOn;
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
endmodule
`default_nettype wire

/* File: test/xp_ctrl_asserts.sv */
// Port-level assertions for the crosspoint control block
`timescale 1ns/1ns
`default_nettype none
module xp_ctrl_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Serial pins and outputs
  input wire logic selectN,
  input wire logic applyN,
  input wire logic serialOut,
  input wire logic [xp_pkg::NUM_OUT-1:0] outEn,
  input wire logic clampOn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // *****
  // Checks
  // *****
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Five samples cover the two-stage pin synchronisers
  a_apply_hold: assert property (applyN [*5] |=> $stable(outEn))
    else $error("routing moved without apply");
  a_clamp_hold: assert property (applyN [*5] |=> $stable(clampOn))
    else $error("clamp moved without apply");
  a_desel_hold: assert property (selectN [*5] |=> $stable(serialOut))
    else $error("shift while deselected");
  a_reset_clear: assert property ($rose(resetn) |->
    !clampOn && !serialOut && outEn == '0)
    else $error("state left after reset");
  a_write_lat: assert property ($rose(s_axi_awvalid && s_axi_wvalid) && !s_axi_bvalid
    |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_read_lat: assert property ($rose(s_axi_arvalid) && !s_axi_rvalid |-> ##2 s_axi_rvalid)
    else $error("read answer late");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
endmodule
`default_nettype wire

/* File: test/xp_host_model.sv */
// Host-side model driving the serial programming pins
`timescale 1ns/1ns
`default_nettype none
module xp_host_model (
  // System clock paces the pins
  input wire logic clk,
  // Serial programming pins
  output logic serialClk,
  output logic serialIn,
  output logic selectN,
  output logic applyN
);
  // *****
  // Pin sequences
  // *****
  initial begin
    serialClk = 1'b0;
    serialIn = 1'b0;
    selectN = 1'b1;
    applyN = 1'b1;
  end
  // Four clocks make each half of an 800 ns link period
  task automatic hold();
    repeat (4) @(posedge clk);
  endtask
  task automatic load(input logic [xp_pkg::WORD_BITS-1:0] w);
    selectN <= 1'b0;
    hold();
    for (int i = xp_pkg::WORD_BITS - 1; i >= 0; i--) begin
      serialIn <= w[i];
      hold();
      serialClk <= 1'b1;
      hold();
      serialClk <= 1'b0;
    end
    // Released data line flips so a stale bit cannot pass
    serialIn <= ~w[0];
    hold();
  endtask
  task automatic upd();
    applyN <= 1'b0;
    hold();
    applyN <= 1'b1;
    hold();
  endtask
  task automatic desel();
    selectN <= 1'b1;
    hold();
  endtask
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the crosspoint serial control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk, resetn, serialClk, serialIn, selectN, applyN, serialOut, clampOn;
  logic [31:0] mainInput, overlayInput, overlaySelect, outData, outEn, rd;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [192:0] act, w;
  logic [31:0] seed = 32'h17749636;
  int errTotal, testsRun, cyc;
  xp_crosspoint_ctrl dut (.*);
  xp_host_model host (.*);
  // *****
  // Helpers
  // *****
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errTotal++;
      wrapUp();
    end
  end
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  task automatic chk(input logic ok, input string m);
    testsRun++;
    if (!ok) begin
      errTotal++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic wrapUp();
    if (errTotal == 0 && testsRun > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge clk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic cmpOut();
    logic [31:0] e, d;
    for (int k = 0; k < 32; k++) begin
      e[k] = act[6*k+5];
      d[k] = overlaySelect[k] ? overlayInput[k] : mainInput[act[6*k+:5]];
    end
    chk(outEn === e, "enable");
    chk((outData & e) === (d & e), "route");
    chk(clampOn === act[192], "clamp");
  endtask
  // *****
  // Scenarios
  // *****
  initial begin
    {resetn, mainInput, overlayInput, overlaySelect} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    act = '0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk({outEn, clampOn, serialOut} === 34'h0, "reset");
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 7; i++) w = {w[160:0], rnd()};
      w[192] = (p == 0);
      host.load(w);
      repeat (5) @(posedge clk);
      cmpOut();
      chk(serialOut === w[192], "chain");
      axr(xp_pkg::STATUS_OFF);
      chk(rd === {16'h0000, 8'hC1, 6'h00, 1'b1, act[192]}, "status");
      axw(xp_pkg::ROUTE_SEL_OFF, 32'h1F);
      chk(br === xp_pkg::RESP_OKAY, "write resp");
      axr(xp_pkg::ROUTE_SEL_OFF);
      chk(rd === 32'h0000001F, "select");
      axr(xp_pkg::ROUTE_DATA_OFF);
      chk(rd[13:8] === w[191:186], "order");
      chk(rd[5:0] === act[191:186], "active field");
      host.desel();
      host.upd();
      repeat (5) @(posedge clk);
      cmpOut();
      host.load(w);
      host.upd();
      act = w;
      for (int j = 0; j < 4; j++) begin
        mainInput <= rnd();
        overlayInput <= rnd();
        overlaySelect <= rnd();
        repeat (5) @(posedge clk);
        cmpOut();
      end
      host.desel();
    end
    axr(4'hC);
    chk(rr === xp_pkg::RESP_SLVERR && rd === 32'h0, "unmapped");
    axw(4'hC, 32'h0);
    chk(br === xp_pkg::RESP_SLVERR, "unmapped write");
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    chk({outEn, clampOn, serialOut} === 34'h0, "midreset");
    resetn <= 1'b1;
    @(posedge clk);
    axr(xp_pkg::ROUTE_DATA_OFF);
    chk(rd === 32'h0, "ranks");
    wrapUp();
  end
endmodule
bind xp_crosspoint_ctrl xp_ctrl_asserts chk_i (
  .clk(clk),
  .resetn(resetn),
  .selectN(selectN),
  .applyN(applyN),
  .serialOut(serialOut),
  .outEn(outEn),
  .clampOn(clampOn),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready)
);
`default_nettype wire
